// ### setpoint_seq_consts.vh
`ifndef SETPOINT_SEQ_CONSTS_VH
`define SETPOINT_SEQ_CONSTS_VH

`define OFF_KIND               5'h00
`define GROSS_COMPARE_KIND     5'h01
`define NET_COMPARE_KIND       5'h02
`define POSITIVE_RELATIVE_KIND 5'h03
`define NEGATIVE_RELATIVE_KIND 5'h04
`define PERCENT_RELATIVE_KIND  5'h05
`define PAUSE_KIND             5'h06
`define DELAY_KIND             5'h07
`define WAIT_STANDSTILL_KIND   5'h08
`define COUNTER_KIND           5'h09
`define AUTO_JOG_KIND          5'h0a
`define CENTER_ZERO_KIND       5'h0b
`define IN_MOTION_KIND         5'h0c
`define CAPACITY_OK_KIND       5'h0d
`define NEG_GROSS_KIND         5'h0e
`define NEG_NET_KIND           5'h0f
`define BATCH_ACTIVE_KIND      5'h10
`define TIMER_KIND             5'h11
`define CONCURRENT_KIND        5'h12

`define CFG_KIND_HI  4
`define CFG_KIND_LO  0
`define CFG_BATCH    5
`define CFG_REF_HI   10
`define CFG_REF_LO   6
`define CFG_END_HI   15
`define CFG_END_LO   11
`define CFG_VAL_HI   31
`define CFG_VAL_LO   16

`define IDX_W        5
`define FIRST_SP     5'h00
`define STEP_ONE     5'h01
`define LAST_SP      5'h13

`define REG_CONTROL  8'h00
`define REG_STATUS   8'h04
`define REG_OUTPUTS  8'h08
`define REG_COUNT    8'h0c
`define SP_SEL_BIT   7
`define SP_IDX_HI    6
`define SP_IDX_LO    2
`define ALIGN_HI     1
`define ALIGN_LO     0
`define ALIGN_OK     2'h0
`define STRB_FULL    4'hf

`define CTL_ENABLE      0
`define CTL_AUTO        1
`define CTL_PERMIT_USED 2
`define CTL_START       8
`define STS_RUNNING     0
`define STS_HALTED      1
`define STS_STEP_HI     12
`define STS_STEP_LO     8

`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

`define ZERO32       32'h0000_0000
`define ZERO16       16'h0000
`define ONE16        16'h0001
`define PCT_SCALE    16'sh0064

`define TICK_CW      25
// 100 ms of 4 ns clocks, sized to the divider so nothing is cut
`define TICK_DEFAULT 25'h17d_7840
`define TICK_ONE     25'h000_0001
`define TICK_ZERO    25'h000_0000

`endif

// ### tenth_tick.v
`timescale 1ns/100ps
`include "setpoint_seq_consts.vh"
module tenth_tick #(
   parameter [`TICK_CW-1:0] CYCLES = `TICK_DEFAULT
) (
   input  wire aclk,
   input  wire aresetn,
   output reg  tick
);
   localparam [`TICK_CW-1:0] TERM = CYCLES - `TICK_ONE;
   reg [`TICK_CW-1:0] count;

   always @(posedge aclk) begin
      if (!aresetn) begin
         count <= `TICK_ZERO;
         tick  <= 1'b0;
      end else if (count >= TERM) begin
         count <= `TICK_ZERO;
         tick  <= 1'b1;
      end else begin
         count <= count + `TICK_ONE;
         tick  <= 1'b0;
      end
   end
endmodule

// ### sp_store.v
`timescale 1ns/100ps
`include "setpoint_seq_consts.vh"
module sp_store (
   input  wire              aclk,
   input  wire              aresetn,
   input  wire              wr_en,
   input  wire [`IDX_W-1:0] wr_addr,
   input  wire [31:0]       wr_data,
   input  wire [`IDX_W-1:0] rd_addr_a,
   output reg  [31:0]       rd_data_a,
   input  wire [`IDX_W-1:0] rd_addr_b,
   output reg  [31:0]       rd_data_b
);
   reg [31:0] mem [0:`LAST_SP];
   integer    i;

   // cleared so every slot reads as an off setpoint after reset
   always @(posedge aclk) begin
      if (!aresetn) begin
         for (i = 0; i <= `LAST_SP; i = i + 1) begin
            mem[i] <= `ZERO32;
         end
         rd_data_a <= `ZERO32;
         rd_data_b <= `ZERO32;
      end else begin
         if (wr_en && wr_addr <= `LAST_SP) begin
            mem[wr_addr] <= wr_data;
         end
         rd_data_a <= (rd_addr_a <= `LAST_SP) ? mem[rd_addr_a] : `ZERO32;
         rd_data_b <= (rd_addr_b <= `LAST_SP) ? mem[rd_addr_b] : `ZERO32;
      end
   end
endmodule

// ### setpoint_batch_sequencer.v
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "setpoint_seq_consts.vh"
// Functional notes
// - continuous setpoints compared every converter update
// - batch steps run singly, ordered, twenty max
// - batch output on until met, then off
// - batching needs enable; auto repeats, manual waits
// - batch flag clear means continuous evaluation
// - gross compare trips on gross weight
// - net compare trips on net weight
// - positive relative: reference plus value
// - negative relative: reference minus value
// - percent relative: percentage of reference
// - pause holds until batch start input
// - delay step waits value tenths
// - standstill step waits for standstill
// - counter step limits consecutive sequences
// - auto jog repeats the preceding fill
// - zero, motion, range status outputs
// - negative gross and net outputs
// - batch active output while running
// - timer alarms if end step late
// - concurrent zero: start step to end step
// - concurrent nonzero: start step plus timer
// - start ignored while run permit off
// - unassigned run permit counts as on
module setpoint_batch_sequencer #(
   parameter [`TICK_CW-1:0] TICK_CYCLES = `TICK_DEFAULT
) (
   input  wire              aclk,
   input  wire              aresetn,
   input  wire [7:0]        awaddr,
   input  wire              awvalid,
   output reg               awready,
   input  wire [31:0]       wdata,
   input  wire [3:0]        wstrb,
   input  wire              wvalid,
   output reg               wready,
   output reg  [1:0]        bresp,
   output reg               bvalid,
   input  wire              bready,
   input  wire [7:0]        araddr,
   input  wire              arvalid,
   output reg               arready,
   output reg  [31:0]       rdata,
   output reg  [1:0]        rresp,
   output reg               rvalid,
   input  wire              rready,
   input  wire              adc_update,
   input  wire [15:0]       gross_weight,
   input  wire [15:0]       net_weight,
   input  wire              standstill,
   input  wire              center_zero,
   input  wire              within_capacity,
   input  wire              batch_start_input,
   input  wire              batch_run_permit_n,
   input  wire              macro_start_batch,
   output reg  [`LAST_SP:0] setpoint_out,
   output reg               batch_running,
   output reg  [`IDX_W-1:0] current_step
);
   localparam ST_IDLE = 1'b0;
   localparam ST_RUN  = 1'b1;

   function is_compare;
      input [4:0] k;
      begin
         is_compare = (k == `GROSS_COMPARE_KIND) || (k == `NET_COMPARE_KIND) ||
                      (k == `POSITIVE_RELATIVE_KIND) || (k == `NEGATIVE_RELATIVE_KIND) ||
                      (k == `PERCENT_RELATIVE_KIND);
      end
   endfunction

   function is_cfg_addr;
      input [7:0] a;
      begin
         is_cfg_addr = a[`SP_SEL_BIT] && (a[`SP_IDX_HI:`SP_IDX_LO] <= `LAST_SP) &&
                       (a[`ALIGN_HI:`ALIGN_LO] == `ALIGN_OK);
      end
   endfunction

   function is_mapped;
      input [7:0] a;
      begin
         is_mapped = (a == `REG_CONTROL) || (a == `REG_STATUS) || (a == `REG_OUTPUTS) ||
                     (a == `REG_COUNT) || is_cfg_addr(a);
      end
   endfunction

   reg                ctl_enable;
   reg                ctl_auto;
   reg                ctl_permit_used;
   reg                start_cmd;
   reg                aw_held;
   reg                w_held;
   reg  [7:0]         aw_addr_q;
   reg  [31:0]        w_data_q;
   reg  [3:0]         w_strb_q;
   reg  [1:0]         start_sync;
   reg  [1:0]         permit_sync;
   reg                start_prev;
   reg signed [15:0]  gw;
   reg signed [15:0]  nw;
   reg                scan_busy;
   reg  [`IDX_W-1:0]  scan_idx;
   reg                s1_valid;
   reg  [`IDX_W-1:0]  s1_idx;
   reg                s2_valid;
   reg  [`IDX_W-1:0]  s2_idx;
   reg  [31:0]        s2_cfg;
   reg                seq_go;
   reg                step_met_q;
   reg  [4:0]         step_kind_q;
   reg  [15:0]        step_val_q;
   reg                state;
   reg                halted;
   reg                jog_pending;
   reg                step_changed;
   reg                start_seen;
   reg  [15:0]        batch_count;
   reg  [15:0]        seq_tenths;
   reg  [15:0]        step_tenths;
   reg                met;
   reg                cont_val;

   wire               tick;
   wire [31:0]        cfg_a;
   wire [31:0]        ref_cfg;
   wire [31:0]        stamp_b;
   wire               wr_go = aw_held && w_held && !bvalid;
   wire               cfg_wr = wr_go && is_cfg_addr(aw_addr_q) && (w_strb_q == `STRB_FULL);
   wire               start_edge = start_sync[1] && !start_prev;
   wire               permit_on = !ctl_permit_used || !permit_sync[1];
   wire               start_evt = permit_on && (start_edge || start_cmd || macro_start_batch);
   wire [4:0]         kind = s2_cfg[`CFG_KIND_HI:`CFG_KIND_LO];
   wire signed [15:0] val = s2_cfg[`CFG_VAL_HI:`CFG_VAL_LO];
   wire [15:0]        uval = s2_cfg[`CFG_VAL_HI:`CFG_VAL_LO];
   wire signed [15:0] refv = ref_cfg[`CFG_VAL_HI:`CFG_VAL_LO];
   wire [`IDX_W-1:0]  st_idx = s2_cfg[`CFG_REF_HI:`CFG_REF_LO];
   wire [`IDX_W-1:0]  en_idx = s2_cfg[`CFG_END_HI:`CFG_END_LO];
   wire signed [16:0] rel_hi = refv + val;
   wire signed [16:0] rel_lo = refv - val;
   wire signed [31:0] pct_lhs = nw * `PCT_SCALE;
   wire signed [31:0] pct_rhs = refv * val;
   wire [15:0]        elapsed = seq_tenths - stamp_b[15:0];
   wire               after_start = batch_running && (current_step >= st_idx);
   wire               in_window = after_start && (current_step < en_idx);
   wire               is_step = s2_cfg[`CFG_BATCH] && (is_compare(kind) ||
                                ((kind >= `PAUSE_KIND) && (kind <= `AUTO_JOG_KIND)));
   wire [16:0]        count_inc = {1'b0, batch_count} + {1'b0, `ONE16};
   wire [31:0]        ctl_word = {23'h00_0000, start_cmd, 5'h00, ctl_permit_used,
                                  ctl_auto, ctl_enable};
   wire [31:0]        status_word = {19'h0_0000, current_step, 6'h00, halted, batch_running};

   tenth_tick #(
      .CYCLES (TICK_CYCLES)
   ) u_tick (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (tick)
   );

   sp_store u_cfg (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .wr_en     (cfg_wr),
      .wr_addr   (aw_addr_q[`SP_IDX_HI:`SP_IDX_LO]),
      .wr_data   (w_data_q),
      .rd_addr_a (scan_idx),
      .rd_data_a (cfg_a),
      .rd_addr_b (cfg_a[`CFG_REF_HI:`CFG_REF_LO]),
      .rd_data_b (ref_cfg)
   );

   // step entry times, read by timers via their start field
   sp_store u_stamp (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .wr_en     (step_changed),
      .wr_addr   (current_step),
      .wr_data   ({`ZERO16, seq_tenths}),
      .rd_addr_a (scan_idx),
      .rd_data_a (),
      .rd_addr_b (cfg_a[`CFG_REF_HI:`CFG_REF_LO]),
      .rd_data_b (stamp_b)
   );

   always @(posedge aclk) begin
      if (!aresetn) begin
         awready   <= 1'b1;
         wready    <= 1'b1;
         bvalid    <= 1'b0;
         bresp     <= `RESP_OKAY;
         aw_held   <= 1'b0;
         w_held    <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q  <= `ZERO32;
         w_strb_q  <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            aw_addr_q <= awaddr;
            aw_held   <= 1'b1;
            awready   <= 1'b0;
         end
         if (wvalid && wready) begin
            w_data_q <= wdata;
            w_strb_q <= wstrb;
            w_held   <= 1'b1;
            wready   <= 1'b0;
         end
         if (wr_go) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            bvalid  <= 1'b1;
            bresp   <= is_mapped(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= `ZERO32;
         rresp   <= `RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rresp   <= is_mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
         case (araddr)
            `REG_CONTROL: rdata <= ctl_word;
            `REG_STATUS:  rdata <= status_word;
            `REG_OUTPUTS: rdata <= {12'h000, setpoint_out};
            `REG_COUNT:   rdata <= {`ZERO16, batch_count};
            default:      rdata <= `ZERO32;
         endcase
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         ctl_enable      <= 1'b0;
         ctl_auto        <= 1'b0;
         ctl_permit_used <= 1'b0;
         start_cmd       <= 1'b0;
      end else begin
         start_cmd <= 1'b0;
         if (wr_go && (aw_addr_q == `REG_CONTROL)) begin
            if (w_strb_q[0]) begin
               ctl_enable      <= w_data_q[`CTL_ENABLE];
               ctl_auto        <= w_data_q[`CTL_AUTO];
               ctl_permit_used <= w_data_q[`CTL_PERMIT_USED];
            end
            start_cmd <= w_strb_q[1] && w_data_q[`CTL_START];
         end
      end
   end

   // pins cross from outside, two stages before use
   always @(posedge aclk) begin
      if (!aresetn) begin
         start_sync  <= 2'h0;
         permit_sync <= 2'h3;
         start_prev  <= 1'b0;
      end else begin
         start_sync  <= {start_sync[0], batch_start_input};
         permit_sync <= {permit_sync[0], batch_run_permit_n};
         start_prev  <= start_sync[1];
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         gw        <= `ZERO16;
         nw        <= `ZERO16;
         scan_busy <= 1'b0;
         scan_idx  <= `FIRST_SP;
         s1_valid  <= 1'b0;
         s1_idx    <= `FIRST_SP;
         s2_valid  <= 1'b0;
         s2_idx    <= `FIRST_SP;
         s2_cfg    <= `ZERO32;
         seq_go    <= 1'b0;
      end else begin
         // an update arriving mid-scan is dropped, scan is only 20 cycles
         if (adc_update && !scan_busy) begin
            gw        <= gross_weight;
            nw        <= net_weight;
            scan_busy <= 1'b1;
            scan_idx  <= `FIRST_SP;
         end else if (scan_busy) begin
            scan_busy <= (scan_idx != `LAST_SP);
            scan_idx  <= scan_idx + `STEP_ONE;
         end
         s1_valid <= scan_busy;
         s1_idx   <= scan_idx;
         s2_valid <= s1_valid;
         s2_idx   <= s1_idx;
         s2_cfg   <= cfg_a;
         seq_go   <= s2_valid && (s2_idx == `LAST_SP);
      end
   end

   always @* begin
      met      = 1'b1;
      cont_val = 1'b0;
      case (kind)
         `GROSS_COMPARE_KIND:     cont_val = (gw >= val);
         `NET_COMPARE_KIND:       cont_val = (nw >= val);
         `POSITIVE_RELATIVE_KIND: cont_val = (nw >= rel_hi);
         `NEGATIVE_RELATIVE_KIND: cont_val = (nw <= rel_lo);
         `PERCENT_RELATIVE_KIND:  cont_val = (pct_lhs >= pct_rhs);
         `CENTER_ZERO_KIND:       cont_val = center_zero;
         `IN_MOTION_KIND:         cont_val = !standstill;
         `CAPACITY_OK_KIND:       cont_val = within_capacity;
         `NEG_GROSS_KIND:         cont_val = gw[15];
         `NEG_NET_KIND:           cont_val = nw[15];
         `BATCH_ACTIVE_KIND:      cont_val = batch_running;
         `TIMER_KIND:             cont_val = in_window && (elapsed >= uval);
         `CONCURRENT_KIND:        cont_val = (uval == `ZERO16) ? in_window :
                                             (after_start && (elapsed < uval));
         default:                 cont_val = 1'b0;
      endcase
      case (kind)
         `PAUSE_KIND:           met = start_seen;
         `DELAY_KIND:           met = (step_tenths >= uval);
         `WAIT_STANDSTILL_KIND: met = standstill;
         default:               met = is_compare(kind) ? cont_val : 1'b1;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         setpoint_out <= 20'h0_0000;
         step_met_q   <= 1'b0;
         step_kind_q  <= `OFF_KIND;
         step_val_q   <= `ZERO16;
      end else if (s2_valid) begin
         // batch step on only while current and unmet
         setpoint_out[s2_idx] <= is_step ? (batch_running && (current_step == s2_idx) &&
                                            is_compare(kind) && !cont_val) : cont_val;
         if (s2_idx == current_step) begin
            step_met_q  <= is_step ? met : 1'b1;
            step_kind_q <= is_step ? kind : `OFF_KIND;
            step_val_q  <= uval;
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         seq_tenths  <= `ZERO16;
         step_tenths <= `ZERO16;
         start_seen  <= 1'b0;
      end else begin
         seq_tenths  <= seq_tenths + (tick ? `ONE16 : `ZERO16);
         step_tenths <= step_changed ? `ZERO16 : step_tenths + (tick ? `ONE16 : `ZERO16);
         // set wins over clear
         start_seen  <= (start_evt && batch_running) ? 1'b1 : (step_changed ? 1'b0 : start_seen);
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         state         <= ST_IDLE;
         batch_running <= 1'b0;
         current_step  <= `FIRST_SP;
         halted        <= 1'b0;
         jog_pending   <= 1'b0;
         step_changed  <= 1'b0;
         batch_count   <= `ZERO16;
      end else begin
         step_changed <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (ctl_enable && start_evt) begin
                  state         <= ST_RUN;
                  batch_running <= 1'b1;
                  current_step  <= `FIRST_SP;
                  halted        <= 1'b0;
                  jog_pending   <= 1'b0;
                  step_changed  <= 1'b1;
                  batch_count   <= `ZERO16;
               end
            end
            ST_RUN: begin
               if (!ctl_enable) begin
                  state         <= ST_IDLE;
                  batch_running <= 1'b0;
               end else if (!permit_on) begin
                  halted <= 1'b1;
               end else if (halted) begin
                  // resume where stopped
                  halted <= !start_evt;
               end else if (seq_go && step_met_q) begin
                  step_changed <= 1'b1;
                  if (step_kind_q == `COUNTER_KIND && count_inc < {1'b0, step_val_q}) begin
                     batch_count  <= count_inc[15:0];
                     current_step <= `FIRST_SP;
                  end else if (step_kind_q == `AUTO_JOG_KIND && !jog_pending &&
                               current_step != `FIRST_SP) begin
                     jog_pending  <= 1'b1;
                     current_step <= current_step - `STEP_ONE;
                  end else if (current_step == `LAST_SP) begin
                     current_step <= `FIRST_SP;
                     jog_pending  <= 1'b0;
                     if (!ctl_auto) begin
                        state         <= ST_IDLE;
                        batch_running <= 1'b0;
                     end
                  end else begin
                     current_step <= current_step + `STEP_ONE;
                     if (step_kind_q == `COUNTER_KIND) begin
                        batch_count <= `ZERO16;
                     end
                     if (step_kind_q == `AUTO_JOG_KIND) begin
                        jog_pending <= 1'b0;
                     end
                  end
               end
            end
            default: begin
               state         <= ST_IDLE;
               batch_running <= 1'b0;
            end
         endcase
      end
   end
endmodule

// ### sbs_checker.sv
`timescale 1ns/100ps
`include "setpoint_seq_consts.vh"
module sbs_checker (
   input wire        aclk,
   input wire        aresetn,
   input wire        awvalid,
   input wire        awready,
   input wire        wvalid,
   input wire        wready,
   input wire        bvalid,
   input wire        bready,
   input wire [1:0]  bresp,
   input wire        arvalid,
   input wire        arready,
   input wire        rvalid,
   input wire        rready,
   input wire [1:0]  rresp,
   input wire [31:0] rdata,
   input wire [4:0]  current_step,
   input wire        batch_running
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer dropped");
   chk_rvalid_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read answer dropped");
   chk_aw_closed: assert property (awvalid && awready |=> !awready)
      else $error("awready not closed");
   chk_ar_closed: assert property (arvalid && arready |=> !arready)
      else $error("arready not closed");
   chk_read_next: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   chk_write_resp: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
      else $error("write answer late");
   chk_resp_codes: assert property (bvalid |-> bresp == `RESP_OKAY || bresp == `RESP_SLVERR)
      else $error("bad write code");
   chk_err_zero: assert property (rvalid && rresp == `RESP_SLVERR |-> rdata == `ZERO32)
      else $error("error read not zero");
   chk_step_range: assert property (current_step <= `LAST_SP)
      else $error("step past last");
   // a scan is longer than eight clocks, so two steps never come closer
   chk_step_once: assert property ($changed(current_step) |=> $stable(current_step) [*8])
      else $error("step moved twice");
   cover property (batch_running ##1 !batch_running);
   cover property (rvalid && rresp == `RESP_SLVERR);
   cover property ($changed(current_step));
endmodule
bind setpoint_batch_sequencer sbs_checker u_sbs_checker (.aclk, .aresetn, .awvalid, .awready,
   .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rresp,
   .rdata, .current_step, .batch_running);

// ### weigh_feed.sv
`timescale 1ns/100ps
module weigh_feed (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [15:0] load,
   output reg         adc_update,
   output reg  [15:0] gross_weight,
   output reg  [15:0] net_weight
);
   reg [4:0] phase;
   always @(posedge aclk) begin
      if (!aresetn) begin
         phase <= 5'h00;
         adc_update <= 1'b0;
         gross_weight <= 16'h0000;
         net_weight <= 16'h0000;
      end else begin
         phase <= phase + 5'h01;
         adc_update <= (phase == 5'h1f);
         // weights move mid-period, never on the sampling pulse
         if (phase == 5'h0f) begin
            gross_weight <= load;
            net_weight <= load - 16'h0010;
         end
      end
   end
endmodule

// ### tb.sv
`timescale 1ns/100ps
`include "setpoint_seq_consts.vh"
module tb;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, seed = 32'h2915_1c02, rdata;
   logic [3:0] wstrb = `STRB_FULL;
   logic awready, wready, bvalid, arready, rvalid, adc_update, batch_running;
   logic [1:0] bresp, rresp;
   logic [15:0] gross_weight, net_weight;
   logic signed [15:0] load = '0;
   logic standstill = 0, center_zero = 0, within_capacity = 0, batch_start_input = 0;
   logic batch_run_permit_n = 1, macro_start_batch = 0;
   logic [19:0] setpoint_out;
   logic [4:0] current_step;
   logic [41:0] notes[$], note;
   int failures = 0, cmp_count = 0;
   setpoint_batch_sequencer #(.TICK_CYCLES(25'h000_000a)) u_setpoint_batch_sequencer (.aclk,
      .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
      .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .adc_update,
      .gross_weight, .net_weight, .standstill, .center_zero, .within_capacity,
      .batch_start_input, .batch_run_permit_n, .macro_start_batch, .setpoint_out,
      .batch_running, .current_step);
   weigh_feed u_weigh_feed (.aclk, .aresetn, .load, .adc_update, .gross_weight, .net_weight);
   initial forever #2 aclk = ~aclk;
   function automatic void nxt();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
   endfunction
   function automatic [31:0] cfg(input [4:0] k, input [4:0] r, input [15:0] v);
      return {v, 5'h00, r, 1'b0, k};
   endfunction
   function automatic [31:0] expo(input run);
      logic signed [15:0] n;
      n = load - 16'sh0010;
      return {22'h00_0000, run, n >= 16'sh0064, n <= 16'sh0028, n >= 16'sh0046,
         n >= 16'sh0032, within_capacity, !standstill, center_zero, n < 0, load >= 16'sh0064};
   endfunction
   task automatic check(input [7:0] a, input [33:0] seen, input [33:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("BAD reg %h exp %h seen %h", a, exp, seen);
      end
   endtask
   task automatic complete_run();
      if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wr(input [7:0] a, input [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask
   task automatic rd(input [7:0] a, input [31:0] d, input [1:0] r = `RESP_OKAY);
      notes.push_back({a, r, d});
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
   endtask
   always @(posedge aclk) begin
      if (rvalid === 1'b1 && rready === 1'b1 && notes.size() > 0) begin
         note = notes.pop_front();
         check(note[41:34], {rresp, rdata}, note[33:0]);
         if (note[41:34] == `REG_OUTPUTS)
            check(note[41:34], setpoint_out, note[19:0]);
         if (note[41:34] == `REG_STATUS)
            check(note[41:34], {current_step, batch_running}, {note[12:8], note[0]});
      end
   end
   // cut a hang short
   initial begin
      #80000;
      failures++;
      complete_run();
   end
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`REG_CONTROL, `ZERO32);
      rd(`REG_STATUS, `ZERO32);
      rd(`REG_OUTPUTS, `ZERO32);
      rd(`REG_COUNT, `ZERO32);
      rd(8'h40, `ZERO32, `RESP_SLVERR);
      // one output per slot keeps every output distinct
      wr(8'h80, cfg(`GROSS_COMPARE_KIND, 5'h00, 16'h0064));
      wr(8'h84, cfg(`NEG_NET_KIND, 5'h00, 16'h0000));
      wr(8'h88, cfg(`CENTER_ZERO_KIND, 5'h00, 16'h0000));
      wr(8'h8c, cfg(`IN_MOTION_KIND, 5'h00, 16'h0000));
      wr(8'h90, cfg(`CAPACITY_OK_KIND, 5'h00, 16'h0000));
      wr(8'h94, cfg(`NET_COMPARE_KIND, 5'h00, 16'h0032));
      wr(8'h98, cfg(`POSITIVE_RELATIVE_KIND, 5'h05, 16'h0014));
      wr(8'h9c, cfg(`NEGATIVE_RELATIVE_KIND, 5'h05, 16'h000a));
      wr(8'ha0, cfg(`PERCENT_RELATIVE_KIND, 5'h05, 16'h00c8));
      wr(8'ha4, cfg(`BATCH_ACTIVE_KIND, 5'h00, 16'h0000));
      wr(8'ha8, cfg(`PAUSE_KIND, 5'h00, 16'h0000) | 32'h0000_0020);
      rd(8'h84, `ZERO32);
      for (int i = 0; i < 4; i++) begin
         nxt();
         load <= {6'h00, seed[9:0]} - 16'h00c8;
         {standstill, center_zero, within_capacity} <= seed[12:10];
         repeat (70) @(posedge aclk);
         rd(`REG_OUTPUTS, expo(1'b0));
      end
      wr(`REG_CONTROL, 32'h0000_0105);
      repeat (100) @(posedge aclk);
      rd(`REG_STATUS, `ZERO32);
      wr(`REG_CONTROL, 32'h0000_0101);
      repeat (600) @(posedge aclk);
      rd(`REG_STATUS, 32'h0000_0a01);
      rd(`REG_OUTPUTS, expo(1'b1));
      batch_start_input <= 1'b1;
      repeat (4) @(posedge aclk);
      batch_start_input <= 1'b0;
      load <= 16'sh0010;
      repeat (600) @(posedge aclk);
      rd(`REG_OUTPUTS, expo(1'b0));
      // batch gross step, started by the macro pulse
      wr(8'h80, cfg(`GROSS_COMPARE_KIND, 5'h00, 16'h0064) | 32'h0000_0020);
      // let a scan see the new step before starting
      repeat (40) @(posedge aclk);
      macro_start_batch <= 1'b1;
      @(posedge aclk);
      macro_start_batch <= 1'b0;
      repeat (100) @(posedge aclk);
      rd(`REG_STATUS, 32'h0000_0001);
      rd(`REG_OUTPUTS, expo(1'b1) | 32'h0000_0001);
      load <= 16'sh0064;
      repeat (100) @(posedge aclk);
      rd(`REG_OUTPUTS, expo(1'b1) & 32'hffff_fffe);
      complete_run();
   end
endmodule
